// ==== lect_consts.vh ====
`ifndef LECT_CONSTS_VH
`define LECT_CONSTS_VH

// ****************************************************************
// Capture modes
// ****************************************************************
`define LECT_MODE_RISE      2'h0
`define LECT_MODE_FALL      2'h1
`define LECT_MODE_BOTH      2'h2

// ****************************************************************
// Widths, limits and reset values
// ****************************************************************
`define LECT_TALLY_W        3
`define LECT_TALLY_MAX      3'h7
`define LECT_TALLY_RST      3'h0
`define LECT_POS_W          32
`define LECT_POS_RST        32'h00000000
`define LECT_CNT_W          16
`define LECT_CNT_RST        16'h0000
`define LECT_SLOTS_MAX      2'h2

`endif

// ==== lect_tally.v ====
`timescale 1ns/1ps
`include "lect_consts.vh"

// Operation
// - At most two selected edges are captured per control cycle and any further one is lost.
// - Only missed edges of the polarity the mode selects count as lost.
// - Each lost tally saturates at seven and never wraps.
// - The first tally shows the losses of the cycle in which slot one captured.
// - The second tally shows the losses of the cycle in which slot two captured.
// - The first visible tally changes only when slot one's event count increments.
// - The second visible tally changes only when slot two's event count increments.
// - Rising mode takes two rising, falling mode two falling, both mode one of each.
// - A rising edge of the job start clears both event counts to zero.
module lect_tally (
    input  wire                      clk_sys_i,
    input  wire                      resetn_i,
    input  wire                      meas_in_i,
    input  wire                      cycle_tick_i,
    input  wire                      job_start_i,
    input  wire [1:0]                mode_i,
    input  wire [`LECT_POS_W-1:0]    position_i,
    output reg  [`LECT_POS_W-1:0]    slot_one_position_o,
    output reg  [`LECT_POS_W-1:0]    slot_two_position_o,
    output reg  [`LECT_CNT_W-1:0]    slot_one_event_count_o,
    output reg  [`LECT_CNT_W-1:0]    slot_two_event_count_o,
    output reg  [`LECT_TALLY_W-1:0]  slot_one_missed_tally_o,
    output reg  [`LECT_TALLY_W-1:0]  slot_two_missed_tally_o
);

// ****************************************************************
// Input synchroniser
// ****************************************************************
reg  meas_s1_r;
reg  meas_s2_r;
reg  meas_s3_r;
reg  meas_lvl_r;
reg  job_start_d_r;

always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
        meas_s1_r     <= 1'b0;
        meas_s2_r     <= 1'b0;
        meas_s3_r     <= 1'b0;
        meas_lvl_r    <= 1'b0;
        job_start_d_r <= 1'b0;
    end else begin
        meas_s1_r     <= meas_in_i;
        meas_s2_r     <= meas_s1_r;
        meas_s3_r     <= meas_s2_r;
        job_start_d_r <= job_start_i;
        if (meas_s2_r == meas_s3_r) begin
            meas_lvl_r <= meas_s3_r;
        end
    end
end

// ****************************************************************
// Edge detection
// ****************************************************************
wire rise_w      = (meas_s2_r == meas_s3_r) && meas_s3_r && !meas_lvl_r;
wire fall_w      = (meas_s2_r == meas_s3_r) && !meas_s3_r && meas_lvl_r;
wire job_rise_w  = job_start_i && !job_start_d_r;

// ****************************************************************
// Edge selection per mode
// ****************************************************************
reg  sel_edge_w;
reg  take_one_w;
reg  take_two_w;
reg  [1:0] taken_r;
reg  one_got_r;
reg  two_got_r;

always @* begin
    sel_edge_w = 1'b0;
    take_one_w = 1'b0;
    take_two_w = 1'b0;
    if (mode_i == `LECT_MODE_RISE) begin
        sel_edge_w = rise_w;
    end else if (mode_i == `LECT_MODE_FALL) begin
        sel_edge_w = fall_w;
    end else if (mode_i == `LECT_MODE_BOTH) begin
        sel_edge_w = rise_w || fall_w;
    end
    if (mode_i == `LECT_MODE_BOTH) begin
        take_one_w = rise_w && !one_got_r;
        take_two_w = fall_w && !two_got_r;
    end else if (sel_edge_w && taken_r < `LECT_SLOTS_MAX) begin
        take_one_w = (taken_r == 2'h0);
        take_two_w = (taken_r == 2'h1);
    end
end

// ****************************************************************
// Lost edge flag
// ****************************************************************
wire lost_w = sel_edge_w && !take_one_w && !take_two_w;

// ****************************************************************
// Per-cycle accumulation
// ****************************************************************
reg  [`LECT_TALLY_W-1:0]  acc_r;
wire [`LECT_TALLY_W-1:0]  acc_now_w;

assign acc_now_w = (lost_w && acc_r != `LECT_TALLY_MAX) ?
                   acc_r + 3'h1 : acc_r;

reg  [`LECT_TALLY_W-1:0]  acc_nxt;
reg  [1:0]                taken_nxt;
reg                       one_got_nxt;
reg                       two_got_nxt;

always @* begin
    acc_nxt     = acc_now_w;
    taken_nxt   = taken_r;
    one_got_nxt = one_got_r;
    two_got_nxt = two_got_r;
    if (cycle_tick_i) begin
        acc_nxt     = `LECT_TALLY_RST;
        taken_nxt   = 2'h0;
        one_got_nxt = 1'b0;
        two_got_nxt = 1'b0;
    end else begin
        if (take_one_w || take_two_w) begin
            taken_nxt = taken_r + 2'h1;
        end
        if (take_one_w) begin
            one_got_nxt = 1'b1;
        end
        if (take_two_w) begin
            two_got_nxt = 1'b1;
        end
    end
end

// ****************************************************************
// Accumulator registers
// ****************************************************************
always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
        acc_r     <= `LECT_TALLY_RST;
        taken_r   <= 2'h0;
        one_got_r <= 1'b0;
        two_got_r <= 1'b0;
    end else begin
        acc_r     <= acc_nxt;
        taken_r   <= taken_nxt;
        one_got_r <= one_got_nxt;
        two_got_r <= two_got_nxt;
    end
end

// ****************************************************************
// Captured positions, pending until cycle end
// ****************************************************************
reg  [`LECT_POS_W-1:0]  pos_one_r;
reg  [`LECT_POS_W-1:0]  pos_two_r;

always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
        pos_one_r <= `LECT_POS_RST;
        pos_two_r <= `LECT_POS_RST;
    end else begin
        if (take_one_w) begin
            pos_one_r <= position_i;
        end
        if (take_two_w) begin
            pos_two_r <= position_i;
        end
    end
end

// ****************************************************************
// Publication at cycle end
// ****************************************************************
reg  [`LECT_POS_W-1:0]    slot_one_position_nxt;
reg  [`LECT_POS_W-1:0]    slot_two_position_nxt;
reg  [`LECT_CNT_W-1:0]    slot_one_event_count_nxt;
reg  [`LECT_CNT_W-1:0]    slot_two_event_count_nxt;
reg  [`LECT_TALLY_W-1:0]  slot_one_missed_tally_nxt;
reg  [`LECT_TALLY_W-1:0]  slot_two_missed_tally_nxt;

always @* begin
    slot_one_position_nxt     = slot_one_position_o;
    slot_two_position_nxt     = slot_two_position_o;
    slot_one_event_count_nxt  = slot_one_event_count_o;
    slot_two_event_count_nxt  = slot_two_event_count_o;
    slot_one_missed_tally_nxt = slot_one_missed_tally_o;
    slot_two_missed_tally_nxt = slot_two_missed_tally_o;
    if (job_rise_w) begin
        slot_one_event_count_nxt = `LECT_CNT_RST;
        slot_two_event_count_nxt = `LECT_CNT_RST;
    end else if (cycle_tick_i) begin
        if (one_got_r) begin
            slot_one_position_nxt     = pos_one_r;
            slot_one_event_count_nxt  = slot_one_event_count_o + 16'h0001;
            slot_one_missed_tally_nxt = acc_r;
        end
        if (two_got_r) begin
            slot_two_position_nxt     = pos_two_r;
            slot_two_event_count_nxt  = slot_two_event_count_o + 16'h0001;
            slot_two_missed_tally_nxt = acc_r;
        end
    end
end

// ****************************************************************
// Output registers
// ****************************************************************
always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
        slot_one_position_o     <= `LECT_POS_RST;
        slot_two_position_o     <= `LECT_POS_RST;
        slot_one_event_count_o  <= `LECT_CNT_RST;
        slot_two_event_count_o  <= `LECT_CNT_RST;
        slot_one_missed_tally_o <= `LECT_TALLY_RST;
        slot_two_missed_tally_o <= `LECT_TALLY_RST;
    end else begin
        slot_one_position_o     <= slot_one_position_nxt;
        slot_two_position_o     <= slot_two_position_nxt;
        slot_one_event_count_o  <= slot_one_event_count_nxt;
        slot_two_event_count_o  <= slot_two_event_count_nxt;
        slot_one_missed_tally_o <= slot_one_missed_tally_nxt;
        slot_two_missed_tally_o <= slot_two_missed_tally_nxt;
    end
end

endmodule // lect_tally

// ==== lect_tally_props.sv ====
`timescale 1ns/1ps
// ****
// Checker
// ****
module lect_tally_props (
    input wire        clk_sys_i,
    input wire        resetn_i,
    input wire        cycle_tick_i,
    input wire        job_start_i,
    input wire [31:0] slot_one_position_o,
    input wire [15:0] slot_one_event_count_o,
    input wire [15:0] slot_two_event_count_o,
    input wire [2:0]  slot_one_missed_tally_o,
    input wire [2:0]  slot_two_missed_tally_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_T1_HOLD: assert property (!$past(cycle_tick_i) |-> $stable(slot_one_missed_tally_o))
        else $error("tally one moved");
    AST_T2_HOLD: assert property (!$past(cycle_tick_i) |-> $stable(slot_two_missed_tally_o))
        else $error("tally two moved");
    AST_T1_CNT: assert property ($changed(slot_one_missed_tally_o) |->
        slot_one_event_count_o == $past(slot_one_event_count_o) + 16'h1) else $error("tally one");
    AST_T2_CNT: assert property ($changed(slot_two_missed_tally_o) |->
        slot_two_event_count_o == $past(slot_two_event_count_o) + 16'h1) else $error("tally two");
    AST_CNT_CLR: assert property ($rose(job_start_i) |=>
        slot_one_event_count_o == 16'h0 && slot_two_event_count_o == 16'h0) else $error("clear");
    AST_P1_HOLD: assert property (!$past(cycle_tick_i) |-> $stable(slot_one_position_o))
        else $error("position one moved");
    AST_C2_SRC: assert property ($changed(slot_two_event_count_o) |->
        $past(cycle_tick_i) || $past(job_start_i)) else $error("count two moved");
    AST_SAME: assert property ($past(cycle_tick_i) && $changed(slot_one_event_count_o) &&
        $changed(slot_two_event_count_o) |-> slot_one_missed_tally_o == slot_two_missed_tally_o)
        else $error("tallies differ");
endmodule // lect_tally_props

bind lect_tally lect_tally_props props (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .cycle_tick_i(cycle_tick_i), .job_start_i(job_start_i),
    .slot_one_position_o(slot_one_position_o), .slot_one_event_count_o(slot_one_event_count_o),
    .slot_two_event_count_o(slot_two_event_count_o),
    .slot_one_missed_tally_o(slot_one_missed_tally_o),
    .slot_two_missed_tally_o(slot_two_missed_tally_o));

// ==== lect_meas_src.sv ====
`timescale 1ns/1ps
module lect_meas_src (
    input  wire clk_sys_i,
    output reg  meas_o
);
    initial meas_o = 1'b0;
    task pulses(input integer n);
        repeat (n) begin
            repeat (6) @(negedge clk_sys_i);
            meas_o = 1'b1;
            repeat (6) @(negedge clk_sys_i);
            meas_o = 1'b0;
        end
    endtask
endmodule // lect_meas_src

// ==== test_lect_tally.sv ====
`timescale 1ns/1ps
module test_lect_tally;
    reg         clk_sys_i = 1'b0;
    reg         resetn_i  = 1'b0;
    reg         tick      = 1'b0;
    reg         job       = 1'b0;
    reg  [1:0]  mode      = 2'h0;
    reg  [31:0] pos       = 32'h0;
    reg  [15:0] e1        = 16'h0;
    reg  [15:0] e2        = 16'h0;
    reg  [31:0] p0        = 32'h0;
    reg  [31:0] ep1       = 32'h0;
    reg  [31:0] ep2       = 32'h0;
    wire        meas;
    wire [31:0] q1, q2;
    wire [15:0] c1, c2;
    wire [2:0]  t1, t2;
    integer     err_total = 0;
    integer     compares  = 0;
    lect_meas_src src (.clk_sys_i(clk_sys_i), .meas_o(meas));
    lect_tally dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .meas_in_i(meas),
        .cycle_tick_i(tick), .job_start_i(job), .mode_i(mode), .position_i(pos),
        .slot_one_position_o(q1), .slot_two_position_o(q2), .slot_one_event_count_o(c1),
        .slot_two_event_count_o(c2), .slot_one_missed_tally_o(t1), .slot_two_missed_tally_o(t2));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    always @(negedge clk_sys_i) pos <= pos + 32'h1;
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== ex) begin
                err_total = err_total + 1;
                $display("unexpected %0s exp %h got %h", nm, ex, got);
            end
        end
    endtask
    task cyc(input [1:0] m, input integer n, input [15:0] d1, d2, input [2:0] x1, x2);
        begin
            @(negedge clk_sys_i) mode = m;
            p0 = pos;
            src.pulses(n);
            repeat (6) @(negedge clk_sys_i);
            tick = 1'b1;
            @(negedge clk_sys_i) tick = 1'b0;
            @(negedge clk_sys_i);
            e1 = e1 + d1;
            e2 = e2 + d2;
            if (d1 != 16'h0) ep1 = p0 + ((m == 2'h1) ? 32'h10 : 32'hA);
            if (d2 != 16'h0) ep2 = p0 + ((m == 2'h0) ? 32'h16 : ((m == 2'h1) ? 32'h1C : 32'h10));
            chk("cnt1", {16'h0, e1}, {16'h0, c1});
            chk("cnt2", {16'h0, e2}, {16'h0, c2});
            chk("tally1", {29'h0, x1}, {29'h0, t1});
            chk("tally2", {29'h0, x2}, {29'h0, t2});
            chk("pos1", ep1, q1);
            chk("pos2", ep2, q2);
        end
    endtask
    task give_verdict;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task sc_job;
        begin
            @(negedge clk_sys_i) job = 1'b1;
            repeat (2) @(negedge clk_sys_i);
            e1 = 16'h0;
            e2 = 16'h0;
            chk("cnt1", {16'h0, e1}, {16'h0, c1});
            chk("cnt2", {16'h0, e2}, {16'h0, c2});
            job = 1'b0;
            cyc(2'h2, 1, 16'h1, 16'h1, 3'h0, 3'h0);
        end
    endtask
    task sc_lost;
        cyc(2'h0, 5, 16'h1, 16'h1, 3'h3, 3'h3);
    endtask
    task sc_saturate;
        cyc(2'h0, 10, 16'h1, 16'h1, 3'h7, 3'h7);
    endtask
    task sc_single;
        cyc(2'h0, 1, 16'h1, 16'h0, 3'h0, 3'h7);
    endtask
    task sc_both;
        cyc(2'h2, 3, 16'h1, 16'h1, 3'h4, 3'h4);
    endtask
    task sc_fall;
        cyc(2'h1, 2, 16'h1, 16'h1, 3'h0, 3'h0);
    endtask
    task sc_none;
        cyc(2'h3, 2, 16'h0, 16'h0, 3'h0, 3'h0);
    endtask
    initial begin
        repeat (4) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        sc_lost;
        sc_saturate;
        sc_single;
        sc_both;
        sc_fall;
        sc_job;
        sc_none;
        give_verdict;
    end
    initial begin
        #100000;
        err_total = err_total + 1;
        give_verdict;
    end
endmodule // test_lect_tally
